// File: verilog/haptic_pkg.sv
// Constants, field layouts and carrier types of the haptic drive control block
package haptic_pkg;

	// Control register: soft reset, standby and operating-mode field
	localparam int          CTRL_RESET_BIT   = 7;
	localparam int          CTRL_STANDBY_BIT = 6;
	localparam logic [2:0]  MODE_PLAY        = 3'h5;
	localparam logic [2:0]  MODE_CAL         = 3'h7;
	localparam logic [2:0]  MODE_RST         = 3'h0;
	localparam logic        STANDBY_RST      = 1'b1;

	// Start values written by the host to the trigger and programming registers
	localparam logic [7:0]  GO_START         = 8'h01;
	localparam logic [7:0]  OTP_START        = 8'h01;

	// Loop control register (bidirectional, open-loop enables, input format)
	localparam int          LOOP_BIDIR_BIT   = 7;
	localparam int          LOOP_MASS_OL_BIT = 5;
	localparam int          LOOP_FMT_BIT     = 3;
	localparam int          LOOP_RES_OL_BIT  = 0;
	localparam logic [7:0]  LOOP_RST         = 8'h80;

	// Feedback control register fields
	localparam int          FB_TYPE_BIT      = 7;
	localparam int          FB_FACTOR_LSB    = 4;
	localparam int          FB_GAIN_LSB      = 2;
	localparam int          FB_BEMF_GAIN_LSB = 0;

	// Calibration and real-time amplitude register reset values
	localparam logic [7:0]  RATED_RST        = 8'h3E;
	localparam logic [7:0]  CLAMP_RST        = 8'h8C;
	localparam logic [7:0]  COMP_RST         = 8'h0C;
	localparam logic [7:0]  BEMF_RST         = 8'h6C;
	localparam logic [7:0]  FBCTL_RST        = 8'h36;
	localparam logic [7:0]  AMP_RST          = 8'h00;

	localparam logic [7:0]  MID_SCALE        = 8'h80;

	// Calibration run time
	localparam int          CLK_MHZ          = 50;
	localparam int          CAL_TIME_US      = 1000;
	localparam int          CAL_CYCLES       = CAL_TIME_US * CLK_MHZ;

	// Calibration registers in ascending address order
	typedef struct packed {
		logic [7:0] rated;
		logic [7:0] clamp;
		logic [7:0] comp;
		logic [7:0] bemf;
		logic [7:0] fbctl;
	} cal_cfg_t;

	// Drive command towards the output stage
	typedef struct packed {
		logic [7:0] mag;
		logic       neg;
		logic       phase_flip;
		logic       level_adjust;
		logic       freq_track;
	} drive_t;

endpackage

// File: verilog/otp_store.sv
// One-time programmable copy of the calibration registers
`timescale 1ns/1ps
module otp_store
	import haptic_pkg::*;
(
	input  wire logic     core_clk,
	input  wire logic     nv_clear_n,
	input  wire logic     program_req,
	input  wire cal_cfg_t prog_data,
	output logic          programmed_ff,
	output cal_cfg_t      stored_ff
);

	// Cleared only at manufacture; core resets leave the contents alone
	always_ff @(posedge core_clk or negedge nv_clear_n) begin
		if (!nv_clear_n) begin
			programmed_ff <= 1'b0;
		end else if (program_req) begin
			programmed_ff <= 1'b1;
		end
	end

	// A second programming request is refused once the fuses are blown
	always_ff @(posedge core_clk or negedge nv_clear_n) begin
		if (!nv_clear_n) begin
			stored_ff <= '0;
		end else if (program_req && !programmed_ff) begin
			stored_ff <= prog_data;
		end
	end

endmodule

// File: verilog/cal_engine.sv
// Auto-calibration sequencer: timed measurement and result computation
`timescale 1ns/1ps
module cal_engine
	import haptic_pkg::*;
#(
	parameter int CYCLES = CAL_CYCLES
)(
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       start,
	input  wire logic [7:0] rated,
	input  wire logic [7:0] bemf_measure,
	output logic            busy_ff,
	output logic            done_ff,
	output logic            fault_ff,
	output logic [7:0]      comp_ff,
	output logic [7:0]      bemf_ff
);

	initial begin
		if (CYCLES < 2) $error("cal_engine: CYCLES must be at least 2");
	end

	logic [31:0] cnt_ff;
	logic        last;

	assign last = busy_ff && (cnt_ff == 32'(CYCLES - 1));

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_ff <= 1'b0;
			cnt_ff  <= '0;
		end else if (start && !busy_ff) begin
			busy_ff <= 1'b1;
			cnt_ff  <= '0;
		end else if (last) begin
			busy_ff <= 1'b0;
		end else if (busy_ff) begin
			cnt_ff <= cnt_ff + 32'd1;
		end
	end

	// Results and fault are presented together with the one-cycle done pulse
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			done_ff  <= 1'b0;
			fault_ff <= 1'b0;
			comp_ff  <= '0;
			bemf_ff  <= '0;
		end else begin
			done_ff <= last;
			if (last) begin
				fault_ff <= (bemf_measure == 8'h00);
				bemf_ff  <= bemf_measure;
				comp_ff  <= (rated > bemf_measure) ? rated - bemf_measure : 8'h00;
			end
		end
	end

endmodule

// File: verilog/haptic_ctrl.sv
// Haptic drive control: modes, calibration, nonvolatile copy and playback mapping
`timescale 1ns/1ps
module haptic_ctrl
	import haptic_pkg::*;
#(
	parameter int CAL_CYCLES_P = CAL_CYCLES
)(
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       nv_clear_n,
	input  wire logic       ctrl_wr,
	input  wire logic [7:0] ctrl_wdata,
	input  wire logic       go_wr,
	input  wire logic [7:0] go_wdata,
	input  wire logic       otp_wr,
	input  wire logic [7:0] otp_wdata,
	input  wire logic       loop_wr,
	input  wire logic [7:0] loop_wdata,
	input  wire logic       rt_wr,
	input  wire logic [7:0] realtime_amplitude_value,
	input  wire logic       cfg_wr,
	input  wire cal_cfg_t   cfg_wdata,
	input  wire logic       enable_pin,
	input  wire logic       overdrive_req_pin,
	input  wire logic       brake_req_pin,
	input  wire logic [7:0] bemf_measure,
	output cal_cfg_t        cfg_rd,
	output logic [2:0]      mode_rd,
	output logic            standby_rd,
	output logic [7:0]      loop_rd,
	output logic            go_rd,
	output logic            diagnostic_fault_flag,
	output logic            otp_status,
	output drive_t          drive
);

	initial begin
		if (CAL_CYCLES_P < 2) $error("haptic_ctrl: CAL_CYCLES_P must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three flops, a change counts when stages two and three agree

	localparam int NPIN = 3;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_filt;

	assign pin_raw = {brake_req_pin, overdrive_req_pin, enable_pin};

	for (genvar i = 0; i < NPIN; i++) begin : g_sync
		logic s1_ff, s2_ff, s3_ff, filt_ff;
		always_ff @(posedge core_clk or negedge arst_n) begin
			if (!arst_n) begin
				s1_ff   <= 1'b0;
				s2_ff   <= 1'b0;
				s3_ff   <= 1'b0;
				filt_ff <= 1'b0;
			end else begin
				s1_ff <= pin_raw[i];
				s2_ff <= s1_ff;
				s3_ff <= s2_ff;
				if (s2_ff == s3_ff) begin
					filt_ff <= s3_ff;
				end
			end
		end
		assign pin_filt[i] = filt_ff;
	end

	logic en_s, od_s, brk_s;
	assign en_s  = pin_filt[0];
	assign od_s  = pin_filt[1];
	assign brk_s = pin_filt[2];

	////////////////////////////////////////////////////////////////////////////
	// Control, loop and real-time registers

	logic        soft_rst, standby_ff;
	logic [2:0]  mode_ff;
	logic [7:0]  loop_ff, amp_ff;
	assign soft_rst = ctrl_wr && ctrl_wdata[CTRL_RESET_BIT];

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_ff    <= MODE_RST;
			standby_ff <= STANDBY_RST;
		end else if (soft_rst) begin
			mode_ff    <= MODE_RST;
			standby_ff <= STANDBY_RST;
		end else if (ctrl_wr) begin
			mode_ff    <= ctrl_wdata[2:0];
			standby_ff <= ctrl_wdata[CTRL_STANDBY_BIT];
		end
	end

	// Bidirectional closed loop is the power-up default
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			loop_ff <= LOOP_RST;
		end else if (soft_rst) begin
			loop_ff <= LOOP_RST;
		end else if (loop_wr) begin
			loop_ff <= loop_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			amp_ff <= AMP_RST;
		end else if (rt_wr) begin
			amp_ff <= realtime_amplitude_value;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Calibration trigger and engine

	logic       go_ff, diag_ff, cal_start, active;
	logic       cal_busy, cal_done, cal_fault;
	logic [7:0] cal_comp, cal_bemf;
	assign active    = !standby_ff && en_s;
	assign cal_start = go_wr && go_wdata == GO_START && mode_ff == MODE_CAL && active && !go_ff;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			go_ff <= 1'b0;
		end else if (soft_rst) begin
			go_ff <= 1'b0;
		end else if (cal_start) begin
			go_ff <= 1'b1;
		end else if (cal_done) begin
			go_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			diag_ff <= 1'b0;
		end else if (soft_rst) begin
			diag_ff <= 1'b0;
		end else if (cal_done) begin
			diag_ff <= cal_fault;
		end
	end

	cal_engine #(
		.CYCLES       (CAL_CYCLES_P)
	) u_cal (
		.core_clk     (core_clk),
		.arst_n       (arst_n),
		.start        (cal_start),
		.rated        (cfg_rd.rated),
		.bemf_measure (bemf_measure),
		.busy_ff      (cal_busy),
		.done_ff      (cal_done),
		.fault_ff     (cal_fault),
		.comp_ff      (cal_comp),
		.bemf_ff      (cal_bemf)
	);

	////////////////////////////////////////////////////////////////////////////
	// Calibration registers and nonvolatile copy

	cal_cfg_t cfg_ff, otp_data;
	logic     otp_done, reload_ff, calibrated_ff, is_resonant;
	assign is_resonant = cfg_ff.fbctl[FB_TYPE_BIT];

	otp_store u_otp (
		.core_clk      (core_clk),
		.nv_clear_n    (nv_clear_n),
		.program_req   (otp_wr && otp_wdata == OTP_START),
		.prog_data     (cfg_ff),
		.programmed_ff (otp_done),
		.stored_ff     (otp_data)
	);

	// Reload from the programmed copy one cycle after either reset
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reload_ff <= 1'b1;
		end else begin
			reload_ff <= soft_rst;
		end
	end

	// Standby and the enable pin never touch these registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_ff <= '{RATED_RST, CLAMP_RST, COMP_RST, BEMF_RST, FBCTL_RST};
		end else if (reload_ff) begin
			if (otp_done) begin
				cfg_ff <= otp_data;
			end else begin
				cfg_ff <= '{RATED_RST, CLAMP_RST, COMP_RST, BEMF_RST, FBCTL_RST};
			end
		end else if (cal_done) begin
			cfg_ff.comp <= cal_comp;
			cfg_ff.bemf <= cal_bemf;
		end else if (cfg_wr) begin
			cfg_ff <= cfg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			calibrated_ff <= 1'b0;
		end else if (cal_done) begin
			calibrated_ff <= !cal_fault;
		end else if (reload_ff) begin
			calibrated_ff <= otp_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Playback mapping

	logic              closed_loop, fmt_unsigned, neg_raw;
	logic signed [8:0] sval;
	logic [7:0]        ucode, smag, mag_raw, mag_lim;
	logic [15:0]       prod_ol, prod_uni, prod_bi;
	assign fmt_unsigned = loop_ff[LOOP_FMT_BIT];
	// Open-loop enable that matters depends on the selected actuator type
	assign closed_loop = is_resonant ? !loop_ff[LOOP_RES_OL_BIT] : !loop_ff[LOOP_MASS_OL_BIT];

	always_comb begin
		// Signed value relative to mid-scale
		if (fmt_unsigned) begin
			sval = $signed({1'b0, amp_ff}) - $signed({1'b0, MID_SCALE});
		end else begin
			sval = $signed({amp_ff[7], amp_ff});
		end
		ucode    = fmt_unsigned ? amp_ff : amp_ff ^ MID_SCALE;
		smag     = sval[8] ? 8'(-sval) : sval[7:0];
		prod_ol  = 16'(smag) * 16'(cfg_ff.clamp);
		prod_uni = 16'(ucode) * 16'(cfg_ff.rated);
		prod_bi  = 16'(smag) * 16'(cfg_ff.rated);
		mag_raw  = 8'h00;
		neg_raw  = 1'b0;
		if (!closed_loop) begin
			mag_raw = prod_ol[14:7];
			neg_raw = sval[8];
		end else if (loop_ff[LOOP_BIDIR_BIT]) begin
			mag_raw = sval[8] ? 8'h00 : prod_bi[14:7];
		end else begin
			mag_raw = prod_uni[15:8];
		end
		if (closed_loop && brk_s) begin
			mag_raw = cfg_ff.clamp;
			neg_raw = 1'b1;
		end else if (closed_loop && od_s) begin
			mag_raw = cfg_ff.clamp;
		end
		mag_lim = (mag_raw > cfg_ff.clamp) ? cfg_ff.clamp : mag_raw;
	end

	drive_t drive_ff;
	logic   playing;

	assign playing = active && mode_ff == MODE_PLAY;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			drive_ff <= '0;
		end else if (playing) begin
			drive_ff.mag          <= mag_lim;
			drive_ff.neg          <= neg_raw && !is_resonant;
			drive_ff.phase_flip   <= neg_raw && is_resonant;
			drive_ff.level_adjust <= closed_loop && calibrated_ff;
			drive_ff.freq_track   <= closed_loop && calibrated_ff && is_resonant;
		end else begin
			drive_ff <= '0;
		end
	end

	assign drive                 = drive_ff;
	assign cfg_rd                = cfg_ff;
	assign mode_rd               = mode_ff;
	assign standby_rd            = standby_ff;
	assign loop_rd               = loop_ff;
	assign go_rd                 = go_ff;
	assign diagnostic_fault_flag = diag_ff;
	assign otp_status            = otp_done;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	property p_go_busy;
		cal_busy |-> go_ff;
	endproperty
	a_go_busy: assert property (p_go_busy) else $error("trigger low while busy");
	property p_go_clear;
		cal_done |=> !go_ff;
	endproperty
	a_go_clear: assert property (p_go_clear) else $error("trigger not cleared");
	property p_diag;
		cal_done && !soft_rst |=> diag_ff == $past(cal_fault);
	endproperty
	a_diag: assert property (p_diag) else $error("diagnostic flag wrong");
	property p_cal_write;
		cal_done && !reload_ff |=> cfg_ff.comp == $past(cal_comp) && cfg_ff.bemf == $past(cal_bemf);
	endproperty
	a_cal_write: assert property (p_cal_write) else $error("results not stored");
	property p_ctrl07;
		ctrl_wr && ctrl_wdata == 8'h07 |=> mode_ff == MODE_CAL && !standby_ff;
	endproperty
	a_ctrl07: assert property (p_ctrl07) else $error("calibration mode not entered");
	property p_otp_sticky;
		otp_done |=> otp_done;
	endproperty
	a_otp_sticky: assert property (p_otp_sticky) else $error("programmed status dropped");
	property p_otp_once;
		otp_done |=> $stable(otp_data);
	endproperty
	a_otp_once: assert property (p_otp_once) else $error("nonvolatile copy changed");
	property p_reload;
		soft_rst ##1 otp_done |=> cfg_ff == $past(otp_data);
	endproperty
	a_reload: assert property (p_reload) else $error("programmed values not restored");
	property p_clamp;
		drive_ff.mag <= cfg_ff.clamp || $changed(cfg_ff.clamp);
	endproperty
	a_clamp: assert property (p_clamp) else $error("drive above overdrive limit");
	property p_bidir_zero;
		playing && closed_loop && loop_ff[LOOP_BIDIR_BIT] && !brk_s && !od_s && sval <= 9'sh000
			|=> drive_ff.mag == 8'h00;
	endproperty
	a_bidir_zero: assert property (p_bidir_zero) else $error("bidirectional low input drives");
	property p_no_freq_mass;
		!is_resonant |=> !drive_ff.freq_track || $changed(is_resonant);
	endproperty
	a_no_freq_mass: assert property (p_no_freq_mass) else $error("frequency tracking on mass");

	c_cal_done: cover property (cal_done && !cal_fault);
	c_cal_fault: cover property (cal_done && cal_fault);
	c_otp_reload: cover property (reload_ff && otp_done);
	c_brake: cover property (drive_ff.neg);

endmodule

// File: tb/host_model.sv
// Host model that issues one-cycle register write strobes towards the control block
`timescale 1ns/1ps
module host_model
	import haptic_pkg::*;
(
	input  wire logic  core_clk,
	output logic       ctrl_wr,
	output logic [7:0] ctrl_wdata,
	output logic       go_wr,
	output logic [7:0] go_wdata,
	output logic       otp_wr,
	output logic [7:0] otp_wdata,
	output logic       loop_wr,
	output logic [7:0] loop_wdata,
	output logic       rt_wr,
	output logic [7:0] realtime_amplitude_value,
	output logic       cfg_wr,
	output cal_cfg_t   cfg_wdata
);
	logic [5:0] stb;

	assign {ctrl_wr, go_wr, otp_wr, loop_wr, rt_wr, cfg_wr} = stb;

	initial begin
		stb = '0;
		{ctrl_wdata, go_wdata, otp_wdata, loop_wdata, realtime_amplitude_value} = '0;
		cfg_wdata = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One write: strobe high for one cycle, data inverted once released
	task automatic wr(input logic [5:0] sel, input logic [7:0] d, input cal_cfg_t c);
		@(negedge core_clk);
		{ctrl_wdata, go_wdata, otp_wdata, loop_wdata, realtime_amplitude_value} = {5{d}};
		cfg_wdata = c;
		stb = sel;
		@(negedge core_clk);
		stb = '0;
		{ctrl_wdata, go_wdata, otp_wdata, loop_wdata, realtime_amplitude_value} = ~{5{d}};
		cfg_wdata = ~c;
	endtask
endmodule

// File: tb/haptic_ctrl_test.sv
// Self-checking bench for the haptic drive control block
`timescale 1ns/1ps
module haptic_ctrl_test;
	import haptic_pkg::*;

	localparam int         CAL_N = 8;
	localparam logic [5:0] CTRL  = 6'h20;
	localparam logic [5:0] GO    = 6'h10;
	localparam logic [5:0] OTP   = 6'h08;
	localparam logic [5:0] LOOP  = 6'h04;
	localparam logic [5:0] RT    = 6'h02;
	localparam logic [5:0] CFG   = 6'h01;

	typedef struct packed {
		logic        res;
		logic [7:0]  loop;
		logic [7:0]  code;
		logic [11:0] exp;
	} play_case_t;

	logic       core_clk, arst_n, nv_clear_n, enable_pin, overdrive_req_pin, brake_req_pin;
	logic       ctrl_wr, go_wr, otp_wr, loop_wr, rt_wr, cfg_wr, standby_rd, go_rd;
	logic       diagnostic_fault_flag, otp_status;
	logic [7:0] ctrl_wdata, go_wdata, otp_wdata, loop_wdata, realtime_amplitude_value;
	logic [7:0] bemf_measure, loop_rd;
	logic [2:0] mode_rd;
	cal_cfg_t   cfg_wdata, cfg_rd, cal, nv_img;
	drive_t     drive;
	int         num_errors, samples_checked, cycles;
	play_case_t plays [13];

	host_model host (
		.core_clk, .ctrl_wr, .ctrl_wdata, .go_wr, .go_wdata, .otp_wr, .otp_wdata,
		.loop_wr, .loop_wdata, .rt_wr, .realtime_amplitude_value, .cfg_wr, .cfg_wdata
	);

	haptic_ctrl #(.CAL_CYCLES_P(CAL_N)) dut (
		.core_clk, .arst_n, .nv_clear_n, .ctrl_wr, .ctrl_wdata, .go_wr, .go_wdata,
		.otp_wr, .otp_wdata, .loop_wr, .loop_wdata, .rt_wr, .realtime_amplitude_value,
		.cfg_wr, .cfg_wdata, .enable_pin, .overdrive_req_pin, .brake_req_pin, .bemf_measure,
		.cfg_rd, .mode_rd, .standby_rd, .loop_rd, .go_rd, .diagnostic_fault_flag,
		.otp_status, .drive
	);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miss("timeout");
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic miss(input string m);
		num_errors++;
		$display("[ERR] %0t %s", $time, m);
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			miss(m);
		end
	endtask

	task automatic chk_cfg(input cal_cfg_t got, input cal_cfg_t exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			miss(m);
		end
	endtask

	task automatic chk_drv(input drive_t got, input logic [11:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			miss(m);
		end
	endtask

	task automatic done(input string t);
		$display("test %s finished", t);
	endtask

	task automatic w(input logic [5:0] s, input logic [7:0] d);
		host.wr(s, d, '0);
	endtask

	task automatic ticks(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Starts calibration, follows the trigger until it drops, then checks the result flag
	task automatic run_cal(input logic [7:0] meas, input logic exp_fault);
		int n;
		bemf_measure = meas;
		w(GO, GO_START);
		chk8({7'h0, go_rd}, 8'h01, "trigger not set");
		ticks(CAL_N / 2);
		chk8({7'h0, go_rd}, 8'h01, "trigger dropped early");
		n = 0;
		while (go_rd !== 1'b0 && n < CAL_N + 4) begin
			ticks(1);
			n++;
		end
		chk8({7'h0, go_rd}, 8'h00, "trigger did not clear");
		chk8({7'h0, diagnostic_fault_flag}, {7'h0, exp_fault}, "fault flag");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		arst_n = 1'b0;
		nv_clear_n = 1'b0;
		enable_pin = 1'b1;
		overdrive_req_pin = 1'b0;
		brake_req_pin = 1'b0;
		bemf_measure = 8'h00;
		cal = {RATED_RST, CLAMP_RST, COMP_RST, BEMF_RST, FBCTL_RST};
		// Rows: resonant type, loop byte, input code, {mag, neg, flip, level, freq}
		plays = '{'{1'b0, 8'h28, 8'hC0, 12'h460}, '{1'b0, 8'h28, 8'h40, 12'h468},
			'{1'b0, 8'h28, 8'hFF, 12'h8A0}, '{1'b0, 8'h28, 8'h00, 12'h8C8},
			'{1'b0, 8'h28, 8'h80, 12'h000}, '{1'b0, 8'h20, 8'hC0, 12'h468},
			'{1'b1, 8'h09, 8'h40, 12'h464}, '{1'b0, 8'h89, 8'h40, 12'h002},
			'{1'b0, 8'h89, 8'hC0, 12'h1F2}, '{1'b1, 8'h88, 8'hC0, 12'h1F3},
			'{1'b1, 8'h88, 8'h40, 12'h003}, '{1'b0, 8'h08, 8'hFF, 12'h3D2},
			'{1'b0, 8'h08, 8'h00, 12'h002}};
		ticks(6);
		arst_n = 1'b1;
		nv_clear_n = 1'b1;
		ticks(2);
		chk8({4'h0, standby_rd, mode_rd}, {4'h0, STANDBY_RST, MODE_RST}, "reset mode");
		chk8(loop_rd, LOOP_RST, "reset loop");
		chk8({6'h0, go_rd, otp_status}, 8'h00, "reset trigger or status");
		chk_cfg(cfg_rd, cal, "reset cfg");
		done("reset");

		w(CTRL, 8'h07);
		chk8({4'h0, standby_rd, mode_rd}, {5'h0, MODE_CAL}, "calibration mode");
		run_cal(8'h00, 1'b1);
		run_cal(8'h10, 1'b0);
		cal.comp = 8'h2E;
		cal.bemf = 8'h10;
		chk_cfg(cfg_rd, cal, "calibration result");
		done("calibration");

		w(CTRL, 8'h47);
		w(GO, GO_START);
		chk8({7'h0, go_rd}, 8'h00, "trigger taken in standby");
		enable_pin = 1'b0;
		ticks(8);
		chk_cfg(cfg_rd, cal, "cfg lost");
		enable_pin = 1'b1;
		done("retention");

		w(CTRL, 8'h05);
		ticks(8);
		foreach (plays[i]) begin
			host.wr(CFG, 8'h00, {cal[39:8], plays[i].res, cal[6:0]});
			w(LOOP, plays[i].loop);
			w(RT, plays[i].code);
			ticks(3);
			chk_drv(drive, plays[i].exp, "playback");
		end
		host.wr(CFG, 8'h00, cal);
		w(LOOP, 8'h88);
		w(RT, 8'hC0);
		brake_req_pin = 1'b1;
		ticks(8);
		chk_drv(drive, 12'h8CA, "brake");
		brake_req_pin = 1'b0;
		overdrive_req_pin = 1'b1;
		ticks(8);
		chk_drv(drive, 12'h8C2, "overdrive");
		overdrive_req_pin = 1'b0;
		ticks(8);
		chk_drv(drive, 12'h1F2, "steady");
		done("playback");

		nv_img = {8'h50, 8'h90, 8'h11, 8'h22, 8'h33};
		host.wr(CFG, 8'h00, nv_img);
		w(OTP, OTP_START);
		chk8({7'h0, otp_status}, 8'h01, "not programmed");
		host.wr(CFG, 8'h00, cal);
		w(OTP, OTP_START);
		w(CTRL, 8'h80);
		ticks(3);
		chk_cfg(cfg_rd, nv_img, "soft reset reload");
		chk8({5'h0, mode_rd}, {5'h0, MODE_RST}, "soft reset mode");
		arst_n = 1'b0;
		ticks(2);
		arst_n = 1'b1;
		ticks(2);
		chk_cfg(cfg_rd, nv_img, "power cycle reload");
		chk8({7'h0, otp_status}, 8'h01, "status lost");
		done("nonvolatile");
		finish_test();
	end
endmodule
